// [core/compare_skip.v]
// decode and execute of the three compare-with-working-register-and-skip instructions
module compare_skip
(
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // phase and instruction from fetch
  input wire i_q_enable,
  input wire [15:0] i_instr,
  input wire i_instr_valid,
  input wire i_next_two_word,
  input wire i_ext_set_enable,
  // core state
  input wire [7:0] i_working_register,
  input wire [3:0] i_bank_select_register,
  input wire [7:0] i_index_base,
  // data memory
  output reg [11:0] o_data_addr,
  output reg o_data_read,
  input wire [7:0] i_data_byte,
  // result to pipeline
  output wire o_claimed,
  output reg o_busy,
  output reg o_discard_fetch,
  output reg o_no_operation,
  output reg o_skip_taken,
  output reg [1:0] o_phase
);
`include "compare_skip_defs.vh"

// state codes
localparam ST_IDLE = 2'h0;
localparam ST_EXEC = 2'h1;
localparam ST_SKIP = 2'h2;
// compare kind held through the instruction
localparam KIND_LESS = 2'h0;
localparam KIND_EQUAL = 2'h1;
localparam KIND_GREATER = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// reset release
reg rst_meta_reg;
reg rst_sync_reg;
always @(posedge i_clk or negedge i_rst_b)
begin
  if (!i_rst_b)
  begin
    rst_meta_reg <= 1'b0;
    rst_sync_reg <= 1'b0;
  end
  else
  begin
    rst_meta_reg <= 1'b1;
    rst_sync_reg <= rst_meta_reg;
  end
end

////////////////////////////////////////////////////////////////////////////////
// decode
wire opc_match;
wire is_less;
wire is_equal;
wire is_greater;
wire access_bit;
wire [7:0] f_field;
wire [2:0] sub_field;
wire [7:0] index_addr;
assign opc_match = (i_instr[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_HI_FIELD);
assign sub_field = i_instr[`OPC_SUB_MSB:`OPC_SUB_LSB];
assign is_less = opc_match && (sub_field == `OPC_SUB_LESS);
assign is_greater = opc_match && (sub_field == `OPC_SUB_GREATER);
assign is_equal = opc_match && (sub_field == `OPC_SUB_EQUAL);
assign access_bit = i_instr[`ACCESS_BIT_POS];
assign f_field = i_instr[`F_FIELD_MSB:`F_FIELD_LSB];
assign index_addr = i_index_base + f_field;
assign o_claimed = i_instr_valid && (is_less || is_equal || is_greater);

// operand address; indexed offset wraps within 8 bits of the base
reg [11:0] addr_next;
always @*
begin
  if (access_bit)
    addr_next = {i_bank_select_register, f_field};
  else if (i_ext_set_enable && (f_field <= `INDEXED_LIMIT))
    addr_next = {4'h0, index_addr};
  else if (f_field < `ACCESS_LOW_LIMIT)
    addr_next = {4'h0, f_field};
  else
    addr_next = {`ACCESS_HIGH_BANK, f_field};
end

////////////////////////////////////////////////////////////////////////////////
// sequencer
reg [1:0] state_reg;
reg [1:0] kind_reg;
reg cond_reg;
reg [1:0] skip_left_reg;
reg two_word_reg;
wire [1:0] skip_words;
assign skip_words = two_word_reg ? `SKIP_TWO_WORDS : `SKIP_ONE_WORD;
// compare only; result never written anywhere
wire [8:0] diff;
assign diff = {1'b0, i_data_byte} - {1'b0, i_working_register};
wire f_less;
wire f_zero;
assign f_less = diff[8];
assign f_zero = (diff[7:0] == 8'h00);

// equality reuses the zero result, so no second comparator
reg cond_next;
always @*
begin
  case (kind_reg)
    KIND_LESS: cond_next = f_less;
    KIND_EQUAL: cond_next = f_zero;
    KIND_GREATER: cond_next = !f_less && !f_zero;
    default: cond_next = 1'b0;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// phase counter; free running, so fetch and execute never drift apart
always @(posedge i_clk or negedge rst_sync_reg)
begin
  if (!rst_sync_reg)
    o_phase <= `PHASE_Q1;
  else if (i_q_enable)
    o_phase <= o_phase + 2'h1;
end

////////////////////////////////////////////////////////////////////////////////
// instruction steps
always @(posedge i_clk or negedge rst_sync_reg)
begin
  if (!rst_sync_reg)
  begin
    state_reg <= ST_IDLE;
    kind_reg <= KIND_LESS;
    cond_reg <= 1'b0;
    skip_left_reg <= 2'h0;
    two_word_reg <= 1'b0;
    o_data_addr <= 12'h000;
    o_data_read <= 1'b0;
    o_busy <= 1'b0;
    o_discard_fetch <= 1'b0;
    o_no_operation <= 1'b0;
    o_skip_taken <= 1'b0;
  end
  else if (i_q_enable)
  begin
    o_data_read <= 1'b0;
    o_discard_fetch <= 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        o_no_operation <= 1'b0;
        o_skip_taken <= 1'b0;
        // decode in Q1
        if (o_phase == `PHASE_Q1 && o_claimed)
        begin
          state_reg <= ST_EXEC;
          o_busy <= 1'b1;
          kind_reg <= is_less ? KIND_LESS : (is_equal ? KIND_EQUAL : KIND_GREATER);
          o_data_addr <= addr_next;
          o_data_read <= 1'b1; // read in Q2
        end
      end
      ST_EXEC:
      begin
        if (o_phase == `PHASE_Q2)
        begin
          // compare in Q2
          cond_reg <= cond_next;
          two_word_reg <= i_next_two_word;
        end
        else if (o_phase == `PHASE_Q4)
        begin
          // no destination written in Q4
          if (cond_reg)
          begin
            state_reg <= ST_SKIP;
            o_discard_fetch <= 1'b1;
            o_no_operation <= 1'b1;
            o_skip_taken <= 1'b1;
            skip_left_reg <= skip_words;
          end
          else
          begin
            state_reg <= ST_IDLE;
            o_busy <= 1'b0;
          end
        end
      end
      ST_SKIP:
      begin
        // one whole no_operation cycle per skipped word
        if (o_phase == `PHASE_Q4)
        begin
          if (skip_left_reg == `SKIP_ONE_WORD)
          begin
            state_reg <= ST_IDLE;
            o_busy <= 1'b0;
            o_no_operation <= 1'b0;
          end
          else
            o_discard_fetch <= 1'b1; // second word also dropped
          skip_left_reg <= skip_left_reg - 2'h1;
        end
      end
      default:
        state_reg <= ST_IDLE;
    endcase
  end
end
endmodule

// [core/compare_skip_defs.vh]
// constants for the compare-and-skip decode and execute unit
`ifndef COMPARE_SKIP_DEFS_VH
`define COMPARE_SKIP_DEFS_VH
`define OPC_HI_FIELD 4'h6
`define OPC_SUB_LESS 3'h0
`define OPC_SUB_EQUAL 3'h1
`define OPC_SUB_GREATER 3'h2
`define ACCESS_BIT_POS 8
`define INDEXED_LIMIT 8'h5f
`define ACCESS_LOW_LIMIT 8'h60
`define ACCESS_HIGH_BANK 4'hf
`define PHASE_Q1 2'h0
`define PHASE_Q2 2'h1
`define PHASE_Q3 2'h2
`define PHASE_Q4 2'h3
`define OPC_HI_MSB 15
`define OPC_HI_LSB 12
`define OPC_SUB_MSB 11
`define OPC_SUB_LSB 9
`define F_FIELD_MSB 7
`define F_FIELD_LSB 0
`define SKIP_ONE_WORD 2'h1
`define SKIP_TWO_WORDS 2'h2
`endif

// [testbench/compare_skip_props.sv]
// assertion checker for the compare-and-skip unit
module compare_skip_props
(
  input wire i_clk,
  input wire i_rst_b,
  input wire i_q_enable,
  input wire [15:0] i_instr,
  input wire i_instr_valid,
  input wire i_ext_set_enable,
  input wire [3:0] i_bank_select_register,
  input wire [7:0] i_index_base,
  input wire [11:0] o_data_addr,
  input wire o_data_read,
  input wire o_claimed,
  input wire o_busy,
  input wire o_discard_fetch,
  input wire o_no_operation,
  input wire [1:0] o_phase
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire [7:0] f = i_instr[7:0];
  sequence take_s;
    i_q_enable && o_phase == 2'h0 && o_claimed && !o_busy;
  endsequence
  ////////////////////////////////////////////////////////////////
  claim_less_a: assert property (i_instr_valid && i_instr[15:9] == 7'h30 |-> o_claimed)
    else $error("less not claimed");
  claim_greater_a: assert property (i_instr_valid && i_instr[15:9] == 7'h32 |-> o_claimed)
    else $error("greater not claimed");
  claim_equal_a: assert property (i_instr_valid && i_instr[15:9] == 7'h31 |-> o_claimed)
    else $error("equal not claimed");
  read_pulse_a: assert property (take_s |=> o_busy && o_data_read && o_phase == 2'h1)
    else $error("read pulse wrong");
  read_end_a: assert property (o_data_read && i_q_enable |=> !o_data_read)
    else $error("read held past one phase");
  bank_sel_a: assert property (take_s ##0 i_instr[8] |=>
    o_data_addr == {$past(i_bank_select_register), $past(f)}) else $error("bank address wrong");
  quick_bank_a: assert property (take_s ##0 (!i_instr[8] && !i_ext_set_enable) |=>
    o_data_addr == {($past(f) < 8'h60) ? 4'h0 : 4'hf, $past(f)}) else $error("quick address wrong");
  indexed_a: assert property (take_s ##0 (!i_instr[8] && i_ext_set_enable && f <= 8'h5f) |=>
    o_data_addr[7:0] == $past(i_index_base) + $past(f)) else $error("indexed address wrong");
  nop_cycle_a: assert property (o_discard_fetch |-> o_no_operation && o_busy)
    else $error("discard outside skip cycle");
  phase_step_a: assert property ($past(i_rst_b, 2) && i_q_enable |=>
    o_phase == $past(o_phase) + 2'h1) else $error("phase did not advance");
  phase_hold_a: assert property (!i_q_enable |=> $stable(o_phase))
    else $error("phase moved without enable");
endmodule

// [testbench/testbench.sv]
// self-checking bench for the compare-and-skip unit
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst_b = 0, i_q_enable = 1, i_instr_valid = 0, i_next_two_word = 0;
  logic i_ext_set_enable = 0, half_rate = 0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_working_register = 8'h00, i_index_base = 8'h10, i_data_byte = 8'h00;
  logic [3:0] i_bank_select_register = 4'h3;
  wire [11:0] o_data_addr;
  wire [1:0] o_phase;
  wire o_data_read, o_claimed, o_busy, o_discard_fetch, o_no_operation, o_skip_taken;
  int error_cnt = 0, checks = 0;
  compare_skip dut (.*);
  initial forever #25 i_clk = ~i_clk;
  // phase steps every clock, or every second clock as from a divider
  always @(negedge i_clk) i_q_enable = half_rate ? !i_q_enable : 1'b1;
  ////////////////////////////////////////////////////////////////
  task chk(input [15:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one instruction: q-steps busy, words dropped, skip flag
  task run(input [15:0] ins, input [7:0] w, d, input two, sk, input [11:0] ad);
    int n, m, dc, nc, st;
    m = half_rate ? 2 : 1;
    n = 0;
    dc = 0;
    nc = 0;
    st = 0;
    @(negedge i_clk);
    {i_instr, i_working_register, i_data_byte, i_next_two_word} = {ins, w, d, two};
    i_instr_valid = 1;
    while (!o_busy && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(o_data_addr, ad);
    i_instr_valid = 0;
    // the decode step before busy rises belongs to the instruction too
    n = m;
    while (o_busy && n < 40)
    begin
      n++;
      dc += o_discard_fetch;
      nc += o_no_operation;
      st |= o_skip_taken;
      @(negedge i_clk);
    end
    chk(n, m * (sk ? (two ? 12 : 8) : 4));
    chk(dc, m * (sk ? (two ? 2 : 1) : 0));
    chk(nc, m * (sk ? (two ? 8 : 4) : 0));
    chk(st, sk);
  endtask
  task t_less;
    run(16'h6112, 8'h40, 8'h3f, 0, 1, 12'h312);
    run(16'h6112, 8'h40, 8'h40, 0, 0, 12'h312);
    run(16'h6112, 8'h01, 8'h80, 0, 0, 12'h312);
    run(16'h6020, 8'h21, 8'h20, 0, 1, 12'h020);
  endtask
  task t_greater;
    run(16'h6480, 8'hfe, 8'hff, 1, 1, 12'hf80);
    run(16'h6480, 8'h7f, 8'h7f, 1, 0, 12'hf80);
    run(16'h6480, 8'h80, 8'h01, 0, 0, 12'hf80);
  endtask
  task t_equal;
    i_ext_set_enable = 1;
    run(16'h625f, 8'h5a, 8'h5a, 0, 1, 12'h06f);
    run(16'h6260, 8'h5a, 8'h5b, 0, 0, 12'hf60);
    i_ext_set_enable = 0;
  endtask
  task t_slow;
    half_rate = 1;
    run(16'h6505, 8'h10, 8'h11, 1, 1, 12'h305);
    run(16'h6105, 8'h10, 8'h11, 0, 0, 12'h305);
    half_rate = 0;
  endtask
  task t_refuse;
    @(negedge i_clk);
    i_instr = 16'h6612;
    i_instr_valid = 1;
    repeat (8) @(negedge i_clk);
    chk(o_claimed, 0);
    chk(o_busy, 0);
    i_instr_valid = 0;
  endtask
  initial
  begin
    repeat (4) @(negedge i_clk);
    i_rst_b = 1;
    repeat (4) @(negedge i_clk);
    t_less;
    t_greater;
    t_equal;
    t_slow;
    t_refuse;
    give_verdict;
  end
  initial
  begin
    #100000;
    error_cnt++;
    give_verdict;
  end
endmodule
bind compare_skip compare_skip_props props (.*);
